// ---- rst_mode_dev.sv ----
// device end: reset pulse width classing, pin latching, mode and busy
// assumes pins arrive asynchronously and are synchronised here
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - range pins 00 software, otherwise hardware
// R2 - hardware mode refuses register access
// R3 - mode changes only through full reset
// R4 - long low pulse shuts down, clears
// R5 - wake on rising edge, host waits
// R6 - 40 to 500 ns is partial
// R7 - partial resets core, keeps config
// R8 - partial reset drops running conversion
// R9 - ready 50 ns after partial release
// R10 - 1.2 us or more is full
// R11 - full release latches base config pins
// R12 - hardware mode latches feature pins too
// R13 - range pins live in hardware mode
// R14 - host waits 120 us after range
// R15 - channel pins sampled at reset release
// R16 - host holds channel pins during busy
// R17 - channel pins read each conversion
// R18 - software mode pins set ref, interface
// R19 - interface pins pick serial, byte, parallel
// R20 - busy rises after trigger until done
// R21 - trigger ignored while busy
// R22 - short pulses ignored, gap counts partial; code still clears READY and drops a running conversion on any low
module rst_mode_dev #(
  parameter int FULL_CYC = rst_mode_pkg::FULL_MIN_CYC,
  parameter int READY_CYC = rst_mode_pkg::PART_READY_CYC,
  parameter int CONV_LEN = rst_mode_pkg::CONV_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  rst_mode_if.dev PINS,
  input wire logic REG_REQ,
  output logic REG_GRANT,
  output logic HW_MODE,
  output logic SHUTDOWN,
  output logic READY,
  output logic [1:0] IF_KIND,
  output logic REF_SEL,
  output logic SER_ONE_LANE,
  output logic CRC_EN,
  output logic [2:0] OSR,
  output logic BURST_EN,
  output logic SEQ_EN,
  output logic [1:0] RANGE,
  output logic [2:0] CHAN_PAIR,
  output logic CORE_RESTART,
  output logic RESULT_VALID
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b10
  } conv_t;

  // two-flop synchronisers for all pins
  localparam int PW = 17;
  logic [PW-1:0] raw;
  logic [PW-1:0] s1_q;
  logic [PW-1:0] s2_q;
  assign raw = {PINS.reset_n, PINS.conversion_trigger, PINS.range_mode_select,
    PINS.channel_pair_select, PINS.sequencer_enable_pin, PINS.crc_check_enable,
    PINS.oversample_ratio_pins, PINS.burst_pin, PINS.reference_source_select,
    PINS.interface_kind_select, PINS.byte_width_select, PINS.single_lane_serial_select};
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_q <= {1'b1, {(PW-1){1'b0}}};
      s2_q <= {1'b1, {(PW-1){1'b0}}};
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  wire rn = s2_q[16];
  wire trig = s2_q[15];
  wire [1:0] rng = s2_q[14:13];
  wire [2:0] chp = s2_q[12:10];
  wire seq_p = s2_q[9];
  wire crc_p = s2_q[8];
  wire [2:0] os_p = s2_q[7:5];
  wire burst_p = s2_q[4];
  wire ref_p = s2_q[3];
  wire kind_p = s2_q[2];
  wire bytew_p = s2_q[1];
  wire lane_p = s2_q[0];

  logic rn_q;
  logic trig_q;
  logic [10:0] low_cnt_q;
  logic [7:0] rdy_cnt_q;
  logic [7:0] conv_cnt_q;
  conv_t st_q;
  wire rise = rn && !rn_q;
  wire fall = !rn && rn_q;
  // R10 full when low long enough
  wire is_full = low_cnt_q >= 11'(FULL_CYC);
  // R6 partial from minimum width; R22 gap up to full treated as partial
  wire is_part = !is_full && low_cnt_q >= 11'(rst_mode_pkg::PART_MIN_CYC);
  wire full_rel = rise && is_full;
  wire part_rel = rise && is_part;
  wire trig_rise = trig && !trig_q;
  // R1 range pins pick the mode
  wire hw_next = rng != rst_mode_pkg::RANGE_SW;
  // R19 interface decode
  wire [1:0] kind_next = !kind_p ? rst_mode_pkg::IF_PAR :
    (bytew_p ? rst_mode_pkg::IF_BYTE : rst_mode_pkg::IF_SERIAL);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rn_q <= 1'b1;
      trig_q <= 1'b0;
      low_cnt_q <= 11'h000;
    end else begin
      rn_q <= rn;
      trig_q <= trig;
      if (rn) begin
        low_cnt_q <= 11'h000;
      end else if (!is_full) begin
        low_cnt_q <= low_cnt_q + 11'h001;
      end
    end
  end

  // R3 mode and config only move in a full reset: cleared while held past full width, latched on release
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      HW_MODE <= 1'b0;
      IF_KIND <= rst_mode_pkg::IF_SERIAL;
      REF_SEL <= 1'b0;
      SER_ONE_LANE <= 1'b0;
      CRC_EN <= 1'b0;
      OSR <= 3'h0;
      BURST_EN <= 1'b0;
      SEQ_EN <= 1'b0;
      SHUTDOWN <= 1'b0;
    end else begin
      // R4 shutdown while held past full width
      SHUTDOWN <= !rn && is_full;
      if (!rn && is_full) begin
        HW_MODE <= 1'b0;
        IF_KIND <= rst_mode_pkg::IF_SERIAL;
        REF_SEL <= 1'b0;
        SER_ONE_LANE <= 1'b0;
        CRC_EN <= 1'b0;
        OSR <= 3'h0;
        BURST_EN <= 1'b0;
        SEQ_EN <= 1'b0;
      end
      // R11 latch base pins; R18 these hold in both modes
      if (full_rel) begin
        HW_MODE <= hw_next;
        IF_KIND <= kind_next;
        REF_SEL <= ref_p;
        SER_ONE_LANE <= lane_p;
        // R12 feature pins latched only in hardware mode
        if (hw_next) begin
          CRC_EN <= crc_p;
          OSR <= os_p;
          BURST_EN <= burst_p;
          SEQ_EN <= seq_p;
        end else begin
          CRC_EN <= 1'b0;
          OSR <= 3'h0;
          BURST_EN <= 1'b0;
          SEQ_EN <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RANGE <= 2'h0;
      CHAN_PAIR <= 3'h0;
      REG_GRANT <= 1'b0;
      READY <= 1'b0;
      rdy_cnt_q <= 8'h00;
      CORE_RESTART <= 1'b0;
    end else begin
      // R13 range follows pins live in hardware mode
      RANGE <= HW_MODE ? rng : 2'h0;
      // R2 registers refused in hardware mode
      REG_GRANT <= REG_REQ && !HW_MODE && READY;
      // R7 core restart pulse, config untouched
      CORE_RESTART <= part_rel;
      // R15 channel pins sampled at release
      if ((full_rel && hw_next) || (part_rel && HW_MODE)) begin
        CHAN_PAIR <= chp;
      // R17 channel pins read during conversion
      end else if (HW_MODE && st_q == ST_CONV) begin
        CHAN_PAIR <= chp;
      end
      // R9 ready a short time after release; R5 from rising edge
      if (!rn) begin
        READY <= 1'b0;
        rdy_cnt_q <= 8'h00;
      end else if (!READY) begin
        rdy_cnt_q <= rdy_cnt_q + 8'h01;
        READY <= rdy_cnt_q >= 8'(READY_CYC - 1);
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= ST_IDLE;
      conv_cnt_q <= 8'h00;
      PINS.busy <= 1'b0;
      RESULT_VALID <= 1'b0;
    end else begin
      RESULT_VALID <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          // R20 busy rises on trigger edge; R21 ignored while busy
          if (trig_rise && READY && rn) begin
            st_q <= ST_CONV;
            PINS.busy <= 1'b1;
            conv_cnt_q <= 8'h00;
          end
        end
        ST_CONV: begin
          conv_cnt_q <= conv_cnt_q + 8'h01;
          if (conv_cnt_q == 8'(CONV_LEN - 1)) begin
            st_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          st_q <= ST_IDLE;
          PINS.busy <= 1'b0;
          RESULT_VALID <= 1'b1;
        end
        default: st_q <= ST_IDLE;
      endcase
      // R8 reset low drops the conversion
      if (!rn) begin
        st_q <= ST_IDLE;
        PINS.busy <= 1'b0;
        RESULT_VALID <= 1'b0;
      end
    end
  end
endmodule : rst_mode_dev

// ---- rst_mode_pkg.sv ----
// shared constants for the reset and mode control link
// assumes a 125 MHz clock on both ends
package rst_mode_pkg;
  localparam int CLK_MHZ = 125;
  localparam int PART_MIN_NS = 40;
  localparam int PART_MAX_NS = 500;
  localparam int FULL_MIN_NS = 1200;
  localparam int PART_READY_NS = 50;
  localparam int REG_WAKE_US = 240;
  localparam int CONV_WAKE_US = 15000;
  localparam int RANGE_SETTLE_US = 120;
  // least times round up, longest round down
  localparam int PART_MIN_CYC = (PART_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PART_MAX_CYC = (PART_MAX_NS * CLK_MHZ) / 1000;
  localparam int FULL_MIN_CYC = (FULL_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int PART_READY_CYC = (PART_READY_NS * CLK_MHZ + 999) / 1000;
  localparam int REG_WAKE_CYC = REG_WAKE_US * CLK_MHZ;
  localparam int CONV_WAKE_CYC = CONV_WAKE_US * CLK_MHZ;
  localparam int RANGE_SETTLE_CYC = RANGE_SETTLE_US * CLK_MHZ;
  localparam int CONV_CYC = 32;
  localparam logic [1:0] RANGE_SW = 2'h0;
  localparam logic [1:0] IF_SERIAL = 2'h0;
  localparam logic [1:0] IF_BYTE = 2'h1;
  localparam logic [1:0] IF_PAR = 2'h2;
  // host apb register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PINS = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_WIDTH = 8'h0C;
  localparam int CTRL_START = 0;
  localparam int CTRL_CONV = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACTIVE = 1;
  localparam int STAT_REG_OK = 2;
  localparam int STAT_CONV_OK = 3;
  localparam int STAT_RANGE_OK = 4;
  localparam logic [31:0] PINS_RESET = 32'h0000_0000;
endpackage : rst_mode_pkg

// ---- rst_mode_if.sv ----
// pin bundle between the host controller and the converter control
// assumes both ends share one clock
`timescale 1ns/1ps
interface rst_mode_if;
  logic reset_n;
  logic conversion_trigger;
  logic busy;
  logic [1:0] range_mode_select;
  logic [2:0] channel_pair_select;
  logic sequencer_enable_pin;
  logic crc_check_enable;
  logic [2:0] oversample_ratio_pins;
  logic burst_pin;
  logic reference_source_select;
  logic interface_kind_select;
  logic byte_width_select;
  logic single_lane_serial_select;
  modport dev (input reset_n, conversion_trigger, range_mode_select, channel_pair_select,
    sequencer_enable_pin, crc_check_enable, oversample_ratio_pins, burst_pin,
    reference_source_select, interface_kind_select, byte_width_select,
    single_lane_serial_select, output busy);
  modport host (output reset_n, conversion_trigger, range_mode_select, channel_pair_select,
    sequencer_enable_pin, crc_check_enable, oversample_ratio_pins, burst_pin,
    reference_source_select, interface_kind_select, byte_width_select,
    single_lane_serial_select, input busy);
endinterface : rst_mode_if

// ---- rst_mode_host.sv ----
// host end: apb slave that drives reset pulses, trigger and config pins
// assumes an apb master on the same clock
`timescale 1ns/1ps
module rst_mode_host #(
  parameter int REG_WAIT = rst_mode_pkg::REG_WAKE_CYC,
  parameter int CONV_WAIT = rst_mode_pkg::CONV_WAKE_CYC,
  parameter int RANGE_WAIT = rst_mode_pkg::RANGE_SETTLE_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  rst_mode_if.host PINS
);
  logic [31:0] pins_q;
  logic [11:0] width_q;
  logic [11:0] low_q;
  logic [23:0] wake_q;
  logic [23:0] rng_q;
  logic active_q;
  logic busy_s1_q;
  logic busy_q;
  wire acc = PSEL && PENABLE;
  wire wr = acc && PWRITE;
  wire hit_ctrl = PADDR == rst_mode_pkg::OFF_CTRL;
  wire hit_pins = PADDR == rst_mode_pkg::OFF_PINS;
  wire hit_stat = PADDR == rst_mode_pkg::OFF_STAT;
  wire hit_width = PADDR == rst_mode_pkg::OFF_WIDTH;
  wire mapped = hit_ctrl || hit_pins || hit_stat || hit_width;
  wire start = wr && hit_ctrl && PWDATA[rst_mode_pkg::CTRL_START] && !active_q;
  wire conv_ok = wake_q >= 24'(CONV_WAIT);
  wire rng_ok = rng_q >= 24'(RANGE_WAIT);
  wire [31:0] stat = {27'h0, rng_ok, conv_ok, wake_q >= 24'(REG_WAIT), active_q, busy_q};
  wire [31:0] rdata = hit_ctrl ? 32'h0 : hit_pins ? pins_q :
    hit_stat ? stat : hit_width ? {20'h0, width_q} : 32'h0;
  // R16 channel pins frozen while busy
  wire pins_wr = wr && hit_pins;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      busy_s1_q <= 1'b0;
      busy_q <= 1'b0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
      pins_q <= rst_mode_pkg::PINS_RESET;
      width_q <= 12'(rst_mode_pkg::FULL_MIN_CYC);
      active_q <= 1'b0;
      low_q <= 12'h000;
      wake_q <= 24'h0;
      rng_q <= 24'h0;
      PINS.reset_n <= 1'b1;
      PINS.conversion_trigger <= 1'b0;
    end else begin
      busy_s1_q <= PINS.busy;
      busy_q <= busy_s1_q;
      PREADY <= PSEL && !PREADY;
      PSLVERR <= PSEL && !PREADY && !mapped;
      PRDATA <= (PSEL && !PWRITE) ? rdata : 32'h0;
      if (pins_wr && PREADY) begin
        if (busy_q) begin
          pins_q <= {PWDATA[31:5], pins_q[4:2], PWDATA[1:0]};
        end else begin
          pins_q <= PWDATA;
        end
      end
      if (wr && hit_width && PREADY) begin
        width_q <= PWDATA[11:0];
      end
      // R14 settle timer restarts on range change
      if (pins_wr && PREADY && PWDATA[1:0] != pins_q[1:0]) begin
        rng_q <= 24'h0;
      end else if (!rng_ok) begin
        rng_q <= rng_q + 24'h1;
      end
      // R3 R4 R6 R10 timed reset low pulse
      if (start && PREADY) begin
        active_q <= 1'b1;
        low_q <= 12'h000;
        PINS.reset_n <= 1'b0;
      end else if (active_q) begin
        low_q <= low_q + 12'h001;
        if (low_q + 12'h001 >= width_q) begin
          active_q <= 1'b0;
          PINS.reset_n <= 1'b1;
        end
      end
      // R5 wake timer from rising edge
      if (active_q) begin
        wake_q <= 24'h0;
      end else if (!conv_ok) begin
        wake_q <= wake_q + 24'h1;
      end
      // R9 R21 trigger only when not busy and no reset pulse is active
      PINS.conversion_trigger <= wr && hit_ctrl && PREADY &&
        PWDATA[rst_mode_pkg::CTRL_CONV] && !busy_q && !active_q;
    end
  end
  assign PINS.range_mode_select = pins_q[1:0];
  assign PINS.channel_pair_select = pins_q[4:2];
  assign PINS.sequencer_enable_pin = pins_q[5];
  assign PINS.crc_check_enable = pins_q[6];
  assign PINS.oversample_ratio_pins = pins_q[9:7];
  assign PINS.burst_pin = pins_q[10];
  assign PINS.reference_source_select = pins_q[11];
  assign PINS.interface_kind_select = pins_q[12];
  assign PINS.byte_width_select = pins_q[13];
  assign PINS.single_lane_serial_select = pins_q[14];
endmodule : rst_mode_host

// ---- rst_mode_sva.sv ----
// link checker: busy timing, trigger shape and channel hold on the pin link
// assumes the shared clock and reset of both ends
`timescale 1ns/1ps
module rst_mode_sva #(
  parameter int BUSY_LEN = rst_mode_pkg::CONV_CYC + 1
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic reset_n,
  input wire logic conversion_trigger,
  input wire logic busy,
  input wire logic [2:0] channel_pair_select
);
  logic [7:0] run_q, age_q, hi_q;
  logic cut_q, conv_q;
  // busy run length, trigger age, reset high time
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      run_q <= 8'h00;
      age_q <= 8'hFF;
      hi_q <= 8'h00;
      cut_q <= 1'b0;
      conv_q <= 1'b0;
    end else begin
      run_q <= busy ? run_q + 8'h01 : 8'h00;
      age_q <= conversion_trigger ? 8'h00 : age_q + {7'h00, age_q != 8'hFF};
      hi_q <= reset_n ? hi_q + {7'h00, hi_q != 8'hFF} : 8'h00;
      cut_q <= !reset_n || (cut_q && busy);
      conv_q <= conversion_trigger || (conv_q && (busy || age_q < 8'h0C));
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  property p_busy_rise;
    conversion_trigger && !busy && hi_q > 8'h0C |-> ##[1:8] busy;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("no busy after trigger");
  property p_busy_cause;
    $rose(busy) |-> age_q > 8'h00 && age_q < 8'h09;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without trigger");
  property p_busy_len;
    $fell(busy) && !cut_q |-> int'(run_q) == BUSY_LEN;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_abort;
    (!reset_n) [*5] |-> ##[0:5] !busy;
  endproperty
  a_abort: assert property (p_abort) else $error("busy kept in reset");
  property p_trig_pulse;
    conversion_trigger |=> !conversion_trigger;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
  property p_trig_quiet;
    conversion_trigger |-> reset_n;
  endproperty
  a_trig_quiet: assert property (p_trig_quiet) else $error("trigger in reset");
  property p_busy_early;
    $rose(busy) |-> hi_q > 8'h06;
  endproperty
  a_busy_early: assert property (p_busy_early) else $error("busy before ready");
  property p_chan_hold;
    conv_q |-> $stable(channel_pair_select);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel pins moved");
  c_conv: cover property ($fell(busy) && !cut_q);
  c_abort: cover property ($fell(busy) && cut_q);
  c_long: cover property ((!reset_n) [*8]);
endmodule : rst_mode_sva

// ---- tb.sv ----
// self-checking bench: apb host end drives the device end over the pin link
// assumes the package, interface, both ends and the link checker
`timescale 1ns/1ps
module tb;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic REG_REQ = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA, rd, p, seed = 32'h5C;
  logic PREADY, PSLVERR, err, HW_MODE, SHUTDOWN, READY, REF_SEL, SER_ONE_LANE, CRC_EN;
  logic BURST_EN, SEQ_EN, CORE_RESTART, RESULT_VALID, REG_GRANT;
  logic [1:0] IF_KIND, RANGE;
  logic [2:0] OSR, CHAN_PAIR;
  logic [10:0] cfg_m;
  int miscompares = 0, n_checks = 0, n_rv = 0, n_cr = 0, n_sd = 0, c0, chan_m;
  int wv[3] = '{4, 5, 19};
  wire [10:0] cfg = {HW_MODE, IF_KIND, REF_SEL, SER_ONE_LANE, CRC_EN, OSR, BURST_EN, SEQ_EN};
  rst_mode_if u_rst_mode_if ();
  rst_mode_dev #(.FULL_CYC(20)) u_rst_mode_dev (.CLK(CLK), .RST(RST), .PINS(u_rst_mode_if),
    .REG_REQ(REG_REQ), .REG_GRANT(REG_GRANT), .HW_MODE(HW_MODE), .SHUTDOWN(SHUTDOWN),
    .READY(READY), .IF_KIND(IF_KIND), .REF_SEL(REF_SEL), .SER_ONE_LANE(SER_ONE_LANE),
    .CRC_EN(CRC_EN), .OSR(OSR), .BURST_EN(BURST_EN), .SEQ_EN(SEQ_EN), .RANGE(RANGE),
    .CHAN_PAIR(CHAN_PAIR), .CORE_RESTART(CORE_RESTART), .RESULT_VALID(RESULT_VALID));
  rst_mode_host #(.REG_WAIT(50), .CONV_WAIT(100), .RANGE_WAIT(30)) u_rst_mode_host (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PINS(u_rst_mode_if));
  rst_mode_sva u_rst_mode_sva (.CLK(CLK), .RST(RST),
    .reset_n(u_rst_mode_if.reset_n), .conversion_trigger(u_rst_mode_if.conversion_trigger),
    .busy(u_rst_mode_if.busy), .channel_pair_select(u_rst_mode_if.channel_pair_select));
  always #4 CLK = ~CLK;
  always @(posedge CLK) begin
    n_rv <= n_rv + int'(RESULT_VALID === 1'b1);
    n_cr <= n_cr + int'(CORE_RESTART === 1'b1);
    n_sd <= n_sd + int'(SHUTDOWN === 1'b1);
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      miscompares++;
      close_out();
    end
  endtask : bound
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // expected latched configuration from pin word
  function automatic logic [10:0] cfg_exp(input logic [31:0] q, input logic hw);
    logic [1:0] k;
    k = q[12] ? (q[13] ? rst_mode_pkg::IF_BYTE : rst_mode_pkg::IF_SERIAL) : rst_mode_pkg::IF_PAR;
    return {hw, k, q[11], q[14], hw & q[6], q[9:7] & {3{hw}}, hw & q[10], hw & q[5]};
  endfunction : cfg_exp
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 9);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
    bound(k, 9);
  endtask : apb
  task automatic wait_stat(input int b, input logic v);
    int k;
    k = 0;
    do begin
      apb(1'b0, rst_mode_pkg::OFF_STAT, 32'h0);
      k++;
    end while (rd[b] !== v && k < 99);
    bound(k, 99);
  endtask : wait_stat
  task automatic wait_busy(input logic v);
    int k;
    k = 0;
    while (u_rst_mode_if.busy !== v && k < 99) begin
      @(negedge CLK);
      k++;
    end
    @(posedge CLK);
    bound(k, 99);
  endtask : wait_busy
  task automatic start;
    apb(1'b1, rst_mode_pkg::OFF_CTRL, 32'h1);
    wait_stat(rst_mode_pkg::STAT_ACTIVE, 1'b0);
    repeat (12) @(posedge CLK);
  endtask : start
  task automatic pulse(input logic [31:0] w);
    apb(1'b1, rst_mode_pkg::OFF_WIDTH, w);
    start();
  endtask : pulse
  initial begin
    repeat (20000) @(posedge CLK);
    bound(1, 1);
  end
  initial begin
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    apb(1'b0, rst_mode_pkg::OFF_WIDTH, 32'h0);
    chk(rd, 32'h96, "width");
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1, "unmapped");
    for (int i = 0; i < 4; i++) begin
      p = rnd();
      p[1:0] = i[1:0];
      p[13:12] = i[1:0];
      apb(1'b1, rst_mode_pkg::OFF_PINS, p);
      pulse(32'h18);
      cfg_m = cfg_exp(p, i != 0);
      chk(cfg, cfg_m, "config");
      chk(RANGE, p[1:0], "range");
      if (i == 0) begin
        apb(1'b0, rst_mode_pkg::OFF_STAT, 32'h0);
        chk(rd[3:2], 2'h0, "wake");
        wait_stat(rst_mode_pkg::STAT_CONV_OK, 1'b1);
        chk(rd[2], 1'b1, "reg wake");
      end
      REG_REQ <= 1'b1;
      repeat (3) @(posedge CLK);
      chk(REG_GRANT, i == 0, "grant");
      REG_REQ <= 1'b0;
      @(posedge CLK);
    end
    chk(n_sd != 0, 1'b1, "shutdown");
    chan_m = p[4:2];
    chk(CHAN_PAIR, chan_m, "chan at reset");
    p = p ^ 32'h7E0;
    p[1:0] = 2'h2;
    p[4:2] = p[4:2] + 3'h1;
    apb(1'b1, rst_mode_pkg::OFF_PINS, p);
    repeat (6) @(posedge CLK);
    chk(cfg, cfg_m, "config held");
    chk(RANGE, 2'h2, "live range");
    chk(CHAN_PAIR, chan_m, "chan idle");
    apb(1'b0, rst_mode_pkg::OFF_STAT, 32'h0);
    chk(rd[rst_mode_pkg::STAT_RANGE_OK], 1'b0, "settling");
    c0 = n_rv;
    apb(1'b1, rst_mode_pkg::OFF_CTRL, 32'h2);
    apb(1'b1, rst_mode_pkg::OFF_CTRL, 32'h2);
    wait_busy(1'b0);
    repeat (4) @(posedge CLK);
    chk(n_rv - c0, 1, "one result");
    chan_m = p[4:2];
    chk(CHAN_PAIR, chan_m, "chan taken");
    apb(1'b0, rst_mode_pkg::OFF_STAT, 32'h0);
    chk(rd[rst_mode_pkg::STAT_RANGE_OK], 1'b1, "settled");
    p[1:0] = 2'h0;
    for (int w = 0; w < 3; w++) begin
      c0 = n_cr;
      p[4:2] = p[4:2] + 3'h1;
      apb(1'b1, rst_mode_pkg::OFF_PINS, p);
      pulse(wv[w]);
      if (w != 0) begin
        chan_m = p[4:2];
      end
      chk(n_cr - c0, w != 0, "restart");
      chk(CHAN_PAIR, chan_m, "chan");
      chk({cfg, READY}, {cfg_m, 1'b1}, "kept");
    end
    apb(1'b1, rst_mode_pkg::OFF_WIDTH, 32'h0A);
    c0 = n_rv;
    apb(1'b1, rst_mode_pkg::OFF_CTRL, 32'h2);
    wait_busy(1'b1);
    start();
    chk(n_rv - c0, 0, "discarded");
    close_out();
  end
endmodule : tb
